// File: hw/rsc_state_ctrl.sv
// Functional notes
// - Starting: missing link module or internal fault
// - Starting: peer Active, sync impossible
// - Starting: peer unknown, fieldbus/keepalive shows Active
// - Starting: vital Ethernet link loss
// - Starting: peer non-Active qualified; B waits longer
// - Starting: peer unknown, no traffic, Active plus relay
// - Starting: peer Active, sync working, Stand-by
// - Active/Inactive: power-off, restart or stop go Not-Configured; Stand-by not on stop
// - Inactive: stand-by press, Not-Configured with request
// - Active: link module lost, peer was Stand-by
// - Active: both channels lost internally, peer was Stand-by
// - Active: fieldbus uncontrolled, peer Stand-by
// - Active: total vital Ethernet failure, peer Stand-by
// - Dual Active: unit B yields differently
// - Active: stand-by press with peer Stand-by
// - Stand-by: project differs, Not-Configured with request
// - Stand-by: incompatible firmware, Not-Configured
// - Stand-by: inactive press or link module lost
// - Stand-by: sync failed four, diagnostics two
// - Stand-by: fieldbus or Ethernet vital failure
// - Stand-by: peer known non-Active, or both lost
// - First two seconds: only power-off, restart, stop or conflict
// - Ordered evaluation, first true condition wins
// - Off or task stopped means Not-Configured
// - Button held one second alone
// - Not-Configured to Starting on request or press
`timescale 1ns/1ps
module rsc_state_ctrl #(
  parameter int unsigned GUARD_CYC = rsc_pkg::ACTIVE_GUARD_CYC,
  parameter int unsigned HOLD_CYC  = rsc_pkg::BUTTON_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Unit identity and run status
  input  wire logic        isUnitB,
  input  wire logic        unitOn,
  input  wire logic        taskRunning,
  input  wire logic        taskTick,
  input  wire logic        restartReq,
  input  wire logic        stopMode,
  // Peer reports over sync_channel_a / sync_channel_b
  input  wire logic        peerKnown,
  input  wire logic        peerActive,
  input  wire logic        peerStandby,
  input  wire logic        peerWasStandby,
  input  wire logic        chanAFail,
  input  wire logic        chanBFail,
  input  wire logic        chanInternalFault,
  // Synchronization services
  input  wire logic        dataSyncOk,
  input  wire logic        forceSyncOk,
  input  wire logic        diagSyncOk,
  input  wire logic        projectDiffers,
  input  wire logic        projectSyncDisabled,
  input  wire logic        firmwareIncompat,
  // Redundancy link module health
  input  wire logic        linkModuleOk,
  // Vital fieldbus and Ethernet monitors
  input  wire logic        fieldbusTrafficSeen,
  input  wire logic        fieldbusAllMonitored,
  input  wire logic        fieldbusAllControlled,
  input  wire logic        keepAlivePeerActive,
  input  wire logic        ethLinkLossAny,
  input  wire logic        ethTotalFail,
  // Operator panel
  input  wire logic [2:0]  panelButtons,
  // State and relay
  output rsc_pkg::rsc_state_t state,
  output logic             peerOffRelay,
  output logic             activeRecent,
  output logic             configPending
);
  import rsc_pkg::*;

  // ----------------------------------------------------------------
  // Button qualification
  // ----------------------------------------------------------------
  logic [BTN_COUNT-1:0] btnPulse;   // Accepted presses, one cycle
  logic [BTN_COUNT-1:0] btnSeen_r;  // Held until next task cycle

  rsc_button_qual #(
    .HOLD_CYC (HOLD_CYC)
  ) uButtons (
    .clock       (clock),
    .reset_n     (reset_n),
    .buttonRaw   (panelButtons),
    .buttonPulse (btnPulse)
  );

  // Presses land between task ticks; latch them for the next one
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      btnSeen_r <= '0;
    end else if (taskTick) begin
      btnSeen_r <= '0;  // Tick uses btnPulse directly, never twice
    end else begin
      btnSeen_r <= btnSeen_r | btnPulse;
    end
  end

  logic pressStandby;   // Qualified stand-by press this tick
  logic pressInactive;  // Qualified inactive press this tick
  assign pressStandby  = btnSeen_r[BTN_STANDBY]  | btnPulse[BTN_STANDBY];
  assign pressInactive = btnSeen_r[BTN_INACTIVE] |
                         btnPulse[BTN_INACTIVE];

  // ----------------------------------------------------------------
  // Active guard timer
  // ----------------------------------------------------------------
  localparam int GW = $clog2(GUARD_CYC + 1);
  logic [GW-1:0] guardCnt_r;  // Counts down after entering Active
  logic          inGuard;     // Still within the first two seconds

  rsc_state_t state_r;    // Current redundancy state
  rsc_state_t state_nxt;  // Decided state for this tick

  assign inGuard = (guardCnt_r != '0);

  // Restarts on every entry into Active
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      guardCnt_r <= '0;
    end else if (taskTick && state_nxt == RSC_ACTIVE &&
                 state_r != RSC_ACTIVE) begin
      guardCnt_r <= GW'(GUARD_CYC);
    end else if (state_r == RSC_ACTIVE && inGuard) begin
      guardCnt_r <= guardCnt_r - GW'(1);
    end else if (state_r != RSC_ACTIVE) begin
      guardCnt_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Per-task qualification counters
  // ----------------------------------------------------------------
  logic [TASK_CNT_W-1:0] nonActCnt_r;   // Peer non-Active streak
  logic [TASK_CNT_W-1:0] unknownCnt_r;  // Peer unknown streak
  logic [TASK_CNT_W-1:0] dualCnt_r;     // Both Active streak
  logic [TASK_CNT_W-1:0] dataFail_r;    // Data/force sync failures
  logic [TASK_CNT_W-1:0] diagFail_r;    // Diagnostics sync failures

  logic condNonAct;   // Peer known and not Active
  logic condUnknown;  // Peer unknown, no vital traffic
  logic condDual;     // Both units Active
  logic condDataBad;  // Data or forcing list not synced
  assign condNonAct  = peerKnown && !peerActive;
  assign condUnknown = !peerKnown && !fieldbusTrafficSeen;
  assign condDual    = state_r == RSC_ACTIVE && peerKnown && peerActive;
  assign condDataBad = !(dataSyncOk && forceSyncOk);

  // Saturating streak update, once per task cycle
  function automatic logic [TASK_CNT_W-1:0] streak(
    input logic                  cond,
    input logic [TASK_CNT_W-1:0] cnt
  );
    if (!cond) begin
      return '0;
    end else if (cnt == '1) begin
      return cnt;
    end
    return cnt + TASK_CNT_W'(1);
  endfunction

  // Streaks only advance on main task ticks
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      nonActCnt_r  <= '0;
      unknownCnt_r <= '0;
      dualCnt_r    <= '0;
      dataFail_r   <= '0;
      diagFail_r   <= '0;
    end else if (!unitOn || !taskRunning) begin
      nonActCnt_r  <= '0;
      unknownCnt_r <= '0;
      dualCnt_r    <= '0;
      dataFail_r   <= '0;
      diagFail_r   <= '0;
    end else if (taskTick) begin
      nonActCnt_r  <= streak(condNonAct, nonActCnt_r);
      unknownCnt_r <= streak(condUnknown, unknownCnt_r);
      dualCnt_r    <= streak(condDual, dualCnt_r);
      dataFail_r   <= streak(condDataBad && peerActive, dataFail_r);
      diagFail_r   <= streak(!diagSyncOk && peerActive, diagFail_r);
    end
  end

  // Unit B qualifies longer to start, yields differently
  logic nonActQual;  // Peer non-Active long enough
  logic unknownQual; // Peer unknown long enough
  logic dualQual;    // Conflict held long enough to yield
  // Limit minus one: the count excludes this tick, so the Nth tick qualifies
  assign nonActQual  = condNonAct && nonActCnt_r >=
    (isUnitB ? TASK_CNT_W'(QUAL_TASKS_B - 1) : TASK_CNT_W'(QUAL_TASKS_A - 1));
  assign unknownQual = condUnknown &&
    unknownCnt_r >= TASK_CNT_W'(UNKNOWN_TASKS - 1);
  assign dualQual    = condDual && dualCnt_r >=
    (isUnitB ? TASK_CNT_W'(DUAL_TASKS_B - 1) : TASK_CNT_W'(DUAL_TASKS_A - 1));

  logic bothChanLost;  // Neither sync channel works
  assign bothChanLost = chanAFail && chanBFail;

  // ----------------------------------------------------------------
  // Transition decision
  // ----------------------------------------------------------------
  logic relayOn_nxt;  // Switch the peer off on this transition
  logic reqSet_nxt;   // Raise a configuration request
  logic goDown;       // Power-off or restart
  assign goDown = !unitOn || restartReq;

  // Each branch tests conditions in order; first hit wins
  always_comb begin
    state_nxt   = state_r;
    relayOn_nxt = 1'b0;
    reqSet_nxt  = 1'b0;
    unique case (state_r)
      RSC_NOT_CONFIGURED: begin
        // Hold while the Active peer runs another project
        if (peerActive && projectDiffers && !projectSyncDisabled) begin
          state_nxt = RSC_NOT_CONFIGURED;
        end else if (configPending || pressStandby) begin
          state_nxt = RSC_STARTING;
        end
      end
      RSC_STARTING: begin
        if (!linkModuleOk || (bothChanLost || chanAFail || chanBFail)
            && chanInternalFault) begin
          state_nxt = RSC_INACTIVE;
        end else if (peerKnown && peerActive &&
                     (!dataSyncOk || !forceSyncOk)) begin
          state_nxt = RSC_INACTIVE;
        end else if (!peerKnown &&
                     (fieldbusTrafficSeen || keepAlivePeerActive)) begin
          state_nxt = RSC_INACTIVE;
        end else if (ethLinkLossAny) begin
          state_nxt = RSC_INACTIVE;
        end else if (nonActQual) begin
          state_nxt = RSC_ACTIVE;
        end else if (unknownQual) begin
          state_nxt   = RSC_ACTIVE;
          relayOn_nxt = 1'b1;
        end else if (peerKnown && peerActive) begin
          state_nxt = RSC_STANDBY;
        end
      end
      RSC_INACTIVE: begin
        if (goDown || stopMode) begin
          state_nxt = RSC_NOT_CONFIGURED;
        end else if (pressStandby) begin
          // Applies even with differing projects when unsynced
          state_nxt  = RSC_NOT_CONFIGURED;
          reqSet_nxt = 1'b1;
        end
      end
      RSC_ACTIVE: begin
        if (goDown || stopMode) begin
          state_nxt = RSC_NOT_CONFIGURED;
        end else if (!inGuard && !linkModuleOk && peerWasStandby) begin
          state_nxt = RSC_INACTIVE;
        end else if (!inGuard && bothChanLost && chanInternalFault &&
                     peerWasStandby) begin
          state_nxt = RSC_INACTIVE;
        end else if (!inGuard && !fieldbusAllControlled &&
                     peerStandby) begin
          state_nxt = RSC_INACTIVE;
        end else if (!inGuard && ethTotalFail && peerStandby) begin
          state_nxt = RSC_INACTIVE;
        end else if (dualQual) begin
          state_nxt = RSC_STANDBY;
        end else if (!inGuard && pressStandby && peerStandby) begin
          state_nxt = RSC_STANDBY;
        end
      end
      RSC_STANDBY: begin
        if (goDown) begin
          state_nxt = RSC_NOT_CONFIGURED;
        end else if (peerActive && projectDiffers &&
                     !projectSyncDisabled) begin
          state_nxt  = RSC_NOT_CONFIGURED;
          reqSet_nxt = 1'b1;
        end else if (peerActive && firmwareIncompat) begin
          state_nxt = RSC_NOT_CONFIGURED;
        end else if (!linkModuleOk || pressInactive) begin
          state_nxt = RSC_INACTIVE;
        end else if (peerActive &&
                     ((condDataBad &&
                       dataFail_r >= TASK_CNT_W'(DATA_FAIL_TASKS - 1)) ||
                      (!diagSyncOk &&
                       diagFail_r >= TASK_CNT_W'(DIAG_FAIL_TASKS - 1)))) begin
          state_nxt = RSC_INACTIVE;
        end else if (peerActive &&
                     (!fieldbusAllMonitored || ethLinkLossAny)) begin
          state_nxt = RSC_INACTIVE;
        end else if (bothChanLost) begin
          state_nxt   = RSC_ACTIVE;
          relayOn_nxt = 1'b1;
        end else if (condNonAct) begin
          state_nxt = RSC_ACTIVE;
        end
      end
      default: begin
        state_nxt = RSC_NOT_CONFIGURED;  // Illegal code recovers
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Updated only on task ticks; off or stopped task forces reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= RSC_NOT_CONFIGURED;
    end else if (!unitOn || !taskRunning) begin
      state_r <= RSC_NOT_CONFIGURED;
    end else if (taskTick) begin
      state_r <= state_nxt;
    end
  end

  // Request set by a stand-by press in Inactive or a project mismatch in Stand-by; power-on sets it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      configPending <= 1'b1;
    end else if (!unitOn) begin
      configPending <= 1'b1;  // Next power-up starts configuring
    end else if (taskTick && taskRunning) begin
      if (reqSet_nxt) begin
        configPending <= 1'b1;  // Set wins over consumption
      end else if (state_r == RSC_NOT_CONFIGURED &&
                   state_nxt == RSC_STARTING) begin
        configPending <= 1'b0;
      end
    end
  end

  // Relay stays on while Active once it switched the peer off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      peerOffRelay <= 1'b0;
    end else if (!unitOn || !taskRunning) begin
      peerOffRelay <= 1'b0;
    end else if (taskTick) begin
      if (relayOn_nxt) begin
        peerOffRelay <= 1'b1;
      end else if (state_nxt != RSC_ACTIVE) begin
        peerOffRelay <= 1'b0;
      end
    end
  end

  assign state        = state_r;
  assign activeRecent = (state_r == RSC_ACTIVE) && inGuard;

endmodule

// File: hw/rsc_pkg.sv
package rsc_pkg;

  // ----------------------------------------------------------------
  // Redundancy states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RSC_NOT_CONFIGURED,
    RSC_STARTING,
    RSC_ACTIVE,
    RSC_STANDBY,
    RSC_INACTIVE
  } rsc_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ         = 40_000_000;
  localparam int unsigned BUTTON_HOLD_MS   = 1000;
  localparam int unsigned BUTTON_HOLD_CYC  =
    BUTTON_HOLD_MS * (CLOCK_HZ / 1000);
  localparam int unsigned ACTIVE_GUARD_MS  = 2000;
  localparam int unsigned ACTIVE_GUARD_CYC =
    ACTIVE_GUARD_MS * (CLOCK_HZ / 1000);

  // Qualifying times, counted in main task cycles
  localparam int unsigned QUAL_TASKS_A     = 8;
  localparam int unsigned QUAL_TASKS_B     = 16;
  localparam int unsigned UNKNOWN_TASKS    = 8;
  localparam int unsigned DUAL_TASKS_A     = 8;
  localparam int unsigned DUAL_TASKS_B     = 4;
  localparam int unsigned DATA_FAIL_TASKS  = 4;
  localparam int unsigned DIAG_FAIL_TASKS  = 2;
  localparam int unsigned TASK_CNT_W       = 5;

  // Button indices
  localparam int unsigned BTN_STANDBY      = 0;
  localparam int unsigned BTN_INACTIVE     = 1;
  localparam int unsigned BTN_TURN_ON      = 2;
  localparam int unsigned BTN_COUNT        = 3;

endpackage

// File: hw/rsc_button_qual.sv
`timescale 1ns/1ps
module rsc_button_qual #(
  parameter int unsigned HOLD_CYC = rsc_pkg::BUTTON_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  // Raw panel buttons
  input  wire logic [rsc_pkg::BTN_COUNT-1:0] buttonRaw,
  // One pulse per accepted press
  output logic      [rsc_pkg::BTN_COUNT-1:0] buttonPulse
);
  import rsc_pkg::*;

  // ----------------------------------------------------------------
  // Per-button hold counters
  // ----------------------------------------------------------------
  localparam int CW = $clog2(HOLD_CYC + 1);

  genvar g;
  generate
    for (g = 0; g < BTN_COUNT; g++) begin : gBtn
      logic [CW-1:0] holdCnt_r;  // Cycles held alone
      logic          alone;      // Only this button pressed
      assign alone = buttonRaw[g] &&
        (buttonRaw == (BTN_COUNT'(1) << g));

      // Count while held alone; any other button restarts it
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          holdCnt_r <= '0;
        end else if (!alone) begin
          holdCnt_r <= '0;
        end else if (holdCnt_r < CW'(HOLD_CYC)) begin
          holdCnt_r <= holdCnt_r + CW'(1);
        end
      end

      // Fires once when the hold time is reached
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          buttonPulse[g] <= 1'b0;
        end else begin
          buttonPulse[g] <= alone &&
            (holdCnt_r == CW'(HOLD_CYC - 1));
        end
      end
    end
  endgenerate

endmodule

// File: testbench/rsc_state_ctrl_monitor.sv
`timescale 1ns/1ps
module rsc_state_ctrl_monitor #(
  parameter int unsigned GUARD_CYC = rsc_pkg::ACTIVE_GUARD_CYC
) (
  // Clock and reset
  input logic                clock,
  input logic                reset_n,
  // Run control
  input logic                unitOn,
  input logic                taskRunning,
  input logic                taskTick,
  input logic                restartReq,
  input logic                stopMode,
  // Peer reports and health
  input logic                peerKnown,
  input logic                peerActive,
  input logic                chanAFail,
  input logic                chanBFail,
  input logic                chanInternalFault,
  input logic                dataSyncOk,
  input logic                forceSyncOk,
  input logic                firmwareIncompat,
  input logic                linkModuleOk,
  input logic                keepAlivePeerActive,
  input logic                ethLinkLossAny,
  // Outputs under watch
  input rsc_pkg::rsc_state_t state,
  input logic                peerOffRelay,
  input logic                activeRecent
);
  import rsc_pkg::*;
  // ------------------------------
  // Helper logic
  // ------------------------------
  logic go;     // Tick with no restart or stop pending
  logic on;     // Unit powered and task running
  int   actCnt; // Cycles spent in Active so far
  assign on = unitOn && taskRunning;
  assign go = taskTick && on && !restartReq && !stopMode;
  // Saturates just past the window so it never wraps
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      actCnt <= 0;
    end else if (state != RSC_ACTIVE) begin
      actCnt <= 0;
    end else if (actCnt < GUARD_CYC + 8) begin
      actCnt <= actCnt + 1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // ------------------------------
  // Properties
  // ------------------------------
  property p_off;
    !on |=> state == RSC_NOT_CONFIGURED;
  endproperty
  a_off: assert property (p_off) else $error("not forced off");
  property p_hold;
    !taskTick && on |=> $stable(state);
  endproperty
  a_hold: assert property (p_hold) else $error("moved off tick");
  property p_restart;
    taskTick && on && state inside {RSC_ACTIVE, RSC_STANDBY, RSC_INACTIVE}
      && (restartReq || (stopMode && state != RSC_STANDBY))
      |=> state == RSC_NOT_CONFIGURED;
  endproperty
  a_restart: assert property (p_restart) else $error("restart kept");
  property p_link;
    go && state == RSC_STARTING && !linkModuleOk |=> state == RSC_INACTIVE;
  endproperty
  a_link: assert property (p_link) else $error("link loss ignored");
  property p_sync;
    go && state == RSC_STARTING && linkModuleOk && !ethLinkLossAny
      && !(chanInternalFault && (chanAFail || chanBFail)) && peerKnown
      && peerActive && dataSyncOk && forceSyncOk |=> state == RSC_STANDBY;
  endproperty
  a_sync: assert property (p_sync) else $error("no standby entry");
  property p_guard;
    go && state == RSC_ACTIVE && activeRecent && !keepAlivePeerActive
      && !(peerKnown && peerActive) |=> state == RSC_ACTIVE;
  endproperty
  a_guard: assert property (p_guard) else $error("left early");
  property p_relay;
    peerOffRelay |-> state == RSC_ACTIVE;
  endproperty
  a_relay: assert property (p_relay) else $error("relay off Active");
  property p_recent;
    $rose(state == RSC_ACTIVE) |-> activeRecent;
  endproperty
  a_recent: assert property (p_recent) else $error("no guard");
  property p_fw;
    go && state == RSC_STANDBY && peerKnown && peerActive && firmwareIncompat
      |=> state == RSC_NOT_CONFIGURED;
  endproperty
  a_fw: assert property (p_fw) else $error("firmware kept");
  // Loose by two cycles each side: latency of the timer is a choice
  property p_guardlen;
    state == RSC_ACTIVE |-> (actCnt < GUARD_CYC - 2) ? activeRecent
      : ((actCnt > GUARD_CYC + 2) ? !activeRecent : 1'b1);
  endproperty
  a_guardlen: assert property (p_guardlen) else $error("window len");
  // ------------------------------
  // Coverage
  // ------------------------------
  c_standby: cover property (state == RSC_STANDBY);
  c_relay: cover property (peerOffRelay);
  c_yield: cover property (state == RSC_ACTIVE ##1 state == RSC_STANDBY);
endmodule
bind rsc_state_ctrl rsc_state_ctrl_monitor #(.GUARD_CYC(GUARD_CYC)) u_mon (.*);

// File: testbench/rsc_peer_model.sv
`timescale 1ns/1ps
module rsc_peer_model (
  // Clock and reset
  input  logic       clock,
  input  logic       reset_n,
  // Scenario control: 0 off, 1 stand-by, 2 Active
  input  logic [1:0] peerMode,
  input  logic       chanDown,
  input  logic       peerOffRelay,
  // Reports seen by the local unit
  output logic       peerKnown,
  output logic       peerActive,
  output logic       peerStandby,
  output logic       peerWasStandby,
  output logic       chanAFail,
  output logic       chanBFail,
  output logic       keepAlivePeerActive
);
  // ------------------------------
  // Peer behaviour
  // ------------------------------
  logic off;  // Peer powered down
  logic seen; // State readable over the channels
  assign off = peerOffRelay || peerMode == 2'h0;
  assign seen = !(off || chanDown);
  // Unknown state toggles peerActive and peerStandby, never a stale value
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      peerKnown <= 1'b0;
      peerActive <= 1'b0;
      peerStandby <= 1'b0;
      peerWasStandby <= 1'b0;
      chanAFail <= 1'b1;
      chanBFail <= 1'b1;
      keepAlivePeerActive <= 1'b0;
    end else begin
      peerKnown <= seen;
      peerActive <= seen ? peerMode == 2'h2 : !peerActive;
      peerStandby <= seen ? peerMode == 2'h1 : !peerStandby;
      // Last known stand-by survives a channel loss
      peerWasStandby <= seen ? peerMode == 2'h1 : peerWasStandby;
      chanAFail <= !seen;
      chanBFail <= !seen;
      keepAlivePeerActive <= !off && peerMode == 2'h2;
    end
  end
endmodule

// File: testbench/rsc_state_ctrl_tb_top.sv
`timescale 1ns/1ps
module rsc_state_ctrl_tb_top;
  import rsc_pkg::*;
  // ------------------------------
  // Signals
  // ------------------------------
  localparam int GUARD = 50; // Short Active guard window
  localparam int HOLD  = 10; // Short button hold
  typedef struct packed {rsc_state_t s; logic r;} rsc_note_t;
  logic clock = 0, reset_n = 0, isUnitB = 0, unitOn = 1, taskRunning = 1;
  logic taskTick = 0, restartReq = 0, stopMode = 0, chanDown = 0;
  logic chanInternalFault = 0, dataSyncOk = 1, forceSyncOk = 1;
  logic diagSyncOk = 1, projectDiffers = 0, projectSyncDisabled = 0;
  logic firmwareIncompat = 0, linkModuleOk = 1, fieldbusTrafficSeen = 0;
  logic fieldbusAllMonitored = 1, fieldbusAllControlled = 1;
  logic ethLinkLossAny = 0, ethTotalFail = 0;
  logic [1:0] peerMode     = 2'h1;
  logic [2:0] panelButtons = 3'h0;
  logic peerKnown, peerActive, peerStandby, peerWasStandby, chanAFail;
  logic chanBFail, keepAlivePeerActive, peerOffRelay, activeRecent;
  logic configPending;
  rsc_state_t state;
  rsc_note_t  notes[$]; // Expected results, oldest first
  rsc_note_t  note;
  int         badCount = 0, testsRun = 0, seed = 88687;
  // ------------------------------
  // Clock, design and peer
  // ------------------------------
  always #12.5 clock = ~clock;
  rsc_state_ctrl #(.GUARD_CYC(GUARD), .HOLD_CYC(HOLD)) u_dut (.*);
  rsc_peer_model u_peer (.*);
  // ------------------------------
  // Compare and close
  // ------------------------------
  task automatic cmp_state(input rsc_state_t e);
    testsRun++;
    if (state !== e) begin
      badCount++;
      $display("BAD %0t state %0d want %0d", $time, state, e);
    end
  endtask
  task automatic cmp_relay(input logic e);
    testsRun++;
    if (peerOffRelay !== e) begin
      badCount++;
      $display("BAD %0t relay %b want %b", $time, peerOffRelay, e);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Result lands on the tick edge; look once it has settled
  always @(posedge clock) begin
    if (reset_n && taskTick) begin
      #2;
      note = notes.pop_front();
      cmp_state(note.s);
      cmp_relay(note.r);
    end
  end
  // ------------------------------
  // Drivers
  // ------------------------------
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask
  // One settle cycle first so the peer sees new inputs
  task automatic tick(input rsc_state_t s, input logic r);
    int gap;
    gap = $unsigned($random(seed)) % 3;
    idle(1);
    notes.push_back('{s, r});
    taskTick = 1'b1;
    idle(1);
    taskTick = 1'b0;
    idle(gap);
  endtask
  task automatic run(input int n, input rsc_state_t a, input rsc_state_t z,
                     input logic rz);
    for (int i = 1; i < n; i++) tick(a, 1'b0);
    tick(z, rz);
  endtask
  task automatic press(input logic [2:0] b);
    panelButtons = b;
    idle(HOLD + 4);
    panelButtons = 3'h0;
  endtask
  task automatic to_standby();
    press(3'h1);
    tick(RSC_NOT_CONFIGURED, 1'b0);
    tick(RSC_STARTING, 1'b0);
    tick(RSC_STANDBY, 1'b0);
  endtask
  // ------------------------------
  // Scenarios for one unit
  // ------------------------------
  task automatic unit_run(input logic b);
    isUnitB = b;
    peerMode = 2'h1;
    if (b) taskRunning = 1'b0;
    else unitOn = 1'b0;
    tick(RSC_NOT_CONFIGURED, 1'b0);
    unitOn = 1'b1;
    taskRunning = 1'b1;
    press(3'h1);
    tick(RSC_STARTING, 1'b0);
    // The tick into Starting already counts toward the streak
    run(b ? 15 : 7, RSC_STARTING, RSC_ACTIVE, 1'b0);
    linkModuleOk = 1'b0;
    tick(RSC_ACTIVE, 1'b0);
    idle(GUARD);
    tick(RSC_INACTIVE, 1'b0);
    linkModuleOk = 1'b1;
    press(3'h3);
    tick(RSC_INACTIVE, 1'b0);
    peerMode = 2'h2;
    to_standby();
    dataSyncOk = 1'b0;
    run(4, RSC_STANDBY, RSC_INACTIVE, 1'b0);
    dataSyncOk = 1'b1;
    to_standby();
    diagSyncOk = 1'b0;
    run(2, RSC_STANDBY, RSC_INACTIVE, 1'b0);
    diagSyncOk = 1'b1;
    to_standby();
    projectDiffers = 1'b1;
    projectSyncDisabled = 1'b1;
    tick(RSC_STANDBY, 1'b0);
    projectSyncDisabled = 1'b0;
    tick(RSC_NOT_CONFIGURED, 1'b0);
    tick(RSC_NOT_CONFIGURED, 1'b0);
    projectDiffers = 1'b0;
    tick(RSC_STARTING, 1'b0);
    tick(RSC_STANDBY, 1'b0);
    firmwareIncompat = 1'b1;
    tick(RSC_NOT_CONFIGURED, 1'b0);
    firmwareIncompat = 1'b0;
    press(3'h1);
    tick(RSC_STARTING, 1'b0);
    tick(RSC_STANDBY, 1'b0);
    peerMode = 2'h1;
    tick(RSC_ACTIVE, 1'b0);
    peerMode = 2'h2;
    run(b ? 4 : 8, RSC_ACTIVE, RSC_STANDBY, 1'b0);
    chanDown = 1'b1;
    tick(RSC_ACTIVE, 1'b1);
    stopMode = 1'b1;
    tick(RSC_NOT_CONFIGURED, 1'b0);
    stopMode = 1'b0;
    peerMode = 2'h0;
    press(3'h1);
    tick(RSC_STARTING, 1'b0);
    run(5, RSC_STARTING, RSC_ACTIVE, 1'b1);
    restartReq = 1'b1;
    tick(RSC_NOT_CONFIGURED, 1'b0);
    restartReq = 1'b0;
    peerMode = b ? 2'h0 : 2'h2;
    fieldbusTrafficSeen = b;
    linkModuleOk = !b;
    press(3'h1);
    tick(RSC_STARTING, 1'b0);
    tick(RSC_INACTIVE, 1'b0);
    fieldbusTrafficSeen = 1'b0;
    linkModuleOk = 1'b1;
    chanDown = 1'b0;
    peerMode = 2'h2;
    to_standby();
    linkModuleOk = 1'b0;
    tick(RSC_INACTIVE, 1'b0);
    linkModuleOk = 1'b1;
    $display("unit %0d sequence done", b);
  endtask
  // ------------------------------
  // Main sequence and watchdog
  // ------------------------------
  initial begin
    idle(12);
    reset_n = 1'b1;
    unit_run(1'b0);
    unit_run(1'b1);
    idle(2); // Let the last compare run
    conclude();
  end
  initial begin
    #(25 * 20000);
    badCount++;
    conclude();
  end
endmodule
